// ===== rfps_pkg.sv
// Package: register map, field positions, reset values and codes of the RF path select block
package rfps_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_DRV_CTRL = 8'h14;
  localparam logic [7:0] ADDR_TX_MOD = 8'h15;
  localparam logic [7:0] ADDR_TX_SEL = 8'h16;
  localparam logic [7:0] ADDR_RX_SEL = 8'h17;
  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] RST_DRV_CTRL = 8'h80;
  localparam logic [7:0] RST_TX_MOD = 8'h00;
  localparam logic [7:0] RST_TX_SEL = 8'h10;
  localparam logic [7:0] RST_RX_SEL = 8'h84;
  localparam logic [7:0] MASK_DRV_CTRL = 8'hfb;
  localparam logic [7:0] MASK_TX_MOD = 8'h40;
  localparam logic [7:0] MASK_TX_SEL = 8'h3f;
  localparam logic [7:0] MASK_RX_SEL = 8'hff;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_INV_B_ON = 7;
  localparam int BIT_INV_A_ON = 6;
  localparam int BIT_INV_B_OFF = 5;
  localparam int BIT_INV_A_OFF = 4;
  localparam int BIT_B_CW = 3;
  localparam int BIT_B_EN = 1;
  localparam int BIT_A_EN = 0;
  localparam int BIT_FORCE_ASK = 6;
  localparam int POS_DRV_SRC = 4;
  localparam int POS_AUX_SEL = 0;
  localparam int POS_UART_SEL = 6;
  localparam int POS_GUARD = 0;
  localparam int GUARD_W = 6;
  // ----------------------------------------
  // Selector codes
  // ----------------------------------------
  localparam logic [1:0] DRV_TRISTATE = 2'h0;
  localparam logic [1:0] DRV_ENCODER = 2'h1;
  localparam logic [1:0] DRV_AUX_IN = 2'h2;
  localparam logic [1:0] DRV_HIGH = 2'h3;
  localparam logic [3:0] AUX_TRISTATE = 4'h0;
  localparam logic [3:0] AUX_LOW = 4'h1;
  localparam logic [3:0] AUX_HIGH = 4'h2;
  localparam logic [3:0] AUX_TEST_BUS = 4'h3;
  localparam logic [3:0] AUX_ENVELOPE = 4'h4;
  localparam logic [3:0] AUX_TX_SERIAL = 4'h5;
  localparam logic [3:0] AUX_RX_SERIAL = 4'h7;
  localparam logic [1:0] UART_LOW = 2'h0;
  localparam logic [1:0] UART_AUX_MANCH = 2'h1;
  localparam logic [1:0] UART_ANALOG = 2'h2;
  localparam logic [1:0] UART_AUX_NRZ = 2'h3;
  // ----------------------------------------
  // Clocking: carrier is 13.56 MHz, system clock 50 MHz
  // ----------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int BIT_RATE_HZ = 106000;
  localparam int BIT_CLK_DIV = CLK_HZ / BIT_RATE_HZ;
  localparam int BIT_DIV_W = 9;
endpackage

// ===== rfps_bit_clock.sv
// Divider that makes the one-cycle bit-clock enable pulse
module rfps_bit_clock #(
  parameter int DIVIDE = rfps_pkg::BIT_CLK_DIV
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic restart_in,
  output logic tick_out
);
  import rfps_pkg::*;
  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (DIVIDE < 2 || DIVIDE >= (1 << BIT_DIV_W)) begin : g_bad
    $error("rfps_bit_clock: DIVIDE out of range");
  end
  typedef struct packed {
    logic [BIT_DIV_W-1:0] count; // Cycles into the current bit
    logic tick;                  // Enable pulse
  } rfps_div_s;
  rfps_div_s state;
  rfps_div_s next_state;
  localparam logic [BIT_DIV_W-1:0] LAST = BIT_DIV_W'(DIVIDE - 1);
  // Next count; restart aligns bit phase to the frame end
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (restart_in) begin
      next_state.count = '0;
    end else if (state.count == LAST) begin
      next_state.count = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 1'b1;
    end
  end
  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign tick_out = state.tick;
endmodule

// ===== rfps_guard_timer.sv
// Receive guard counter: holds the receiver off for a number of bit-clocks
module rfps_guard_timer #(
  parameter int WIDTH = rfps_pkg::GUARD_W
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [WIDTH-1:0] count_in,
  input wire logic tick_in,
  output logic busy_out
);
  import rfps_pkg::*;
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad
    $error("rfps_guard_timer: WIDTH out of range");
  end
  typedef struct packed {
    logic [WIDTH-1:0] left; // Bit-clocks still to wait
  } rfps_guard_s;
  rfps_guard_s state;
  rfps_guard_s next_state;
  // Load on start, count down on each bit-clock
  always_comb begin
    next_state = state;
    if (start_in) begin
      next_state.left = count_in;
    end else if (tick_in && state.left != '0) begin
      next_state.left = state.left - 1'b1;
    end
  end
  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  // Busy while any bit-clock remains; zero count means no guard
  assign busy_out = (state.left != '0);
endmodule

// ===== rfps_path_select.sv
// Antenna driver, aux pin and receive path select logic with receive guard delay
//
// Local design decision: strobed register access.
module rfps_path_select #(
  parameter int BIT_DIVIDE = rfps_pkg::BIT_CLK_DIV
) (
  input wire logic clock_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  // Carrier and modulation sources
  input wire logic carrier_in,
  input wire logic envelope_in,
  input wire logic tx_serial_in,
  input wire logic rx_serial_in,
  input wire logic [7:0] test_bus_in,
  input wire logic [2:0] test_bus_bit_pick_in,
  input wire logic soft_power_down_in,
  // Aux modulation pins
  input wire logic aux_mod_in_pin_in,
  output logic aux_mod_out_pin_out,
  output logic aux_mod_out_pin_oe_out,
  // Antenna drivers
  output logic antenna_driver_a_pin_out,
  output logic antenna_driver_a_pin_oe_out,
  output logic antenna_driver_b_pin_out,
  output logic antenna_driver_b_pin_oe_out,
  output logic force_full_ask_out,
  // Receive path
  input wire logic analog_rx_in,
  input wire logic tx_done_in,
  input wire logic cmd_is_receive_in,
  input wire logic field_on_in,
  output logic cl_uart_data_out,
  output logic rx_enable_out
);
  import rfps_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] antenna_driver_control; // Inversion, CW and enables
    logic [7:0] tx_modulation_control;  // Force full ASK
    logic [7:0] tx_source_select;       // Driver source and aux out select
    logic [7:0] rx_source_and_guard;    // UART select and guard count
    logic [7:0] rdata;                  // Read data, valid one cycle after strobe
    logic drv_a;                        // Registered driver A level
    logic drv_a_oe;                     // Driver A enable
    logic drv_b;                        // Registered driver B level
    logic drv_b_oe;                     // Driver B enable
    logic aux_out;                      // Aux out level
    logic aux_oe;                       // Aux out enable
    logic uart_data;                    // Contactless UART input
    logic field_prev;                   // Field level last cycle
  } rfps_state_s;
  rfps_state_s state;
  rfps_state_s next_state;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic inv_b_on;
  logic inv_a_on;
  logic inv_b_off;
  logic inv_a_off;
  logic b_cw;
  logic b_en;
  logic a_en;
  logic [1:0] driver_source_select;
  logic [3:0] aux_out_select;
  logic [1:0] cl_uart_input_select;
  logic [GUARD_W-1:0] receive_guard_count;
  assign inv_b_on = state.antenna_driver_control[BIT_INV_B_ON];
  assign inv_a_on = state.antenna_driver_control[BIT_INV_A_ON];
  assign inv_b_off = state.antenna_driver_control[BIT_INV_B_OFF];
  assign inv_a_off = state.antenna_driver_control[BIT_INV_A_OFF];
  assign b_cw = state.antenna_driver_control[BIT_B_CW];
  assign b_en = state.antenna_driver_control[BIT_B_EN];
  assign a_en = state.antenna_driver_control[BIT_A_EN];
  assign driver_source_select = state.tx_source_select[POS_DRV_SRC +: 2];
  assign aux_out_select = state.tx_source_select[POS_AUX_SEL +: 4];
  assign cl_uart_input_select = state.rx_source_and_guard[POS_UART_SEL +: 2];
  assign receive_guard_count = state.rx_source_and_guard[POS_GUARD +: GUARD_W];

  // ----------------------------------------
  // Guard timer and bit clock
  // ----------------------------------------
  logic bit_tick;
  logic guard_busy;
  logic field_rise;
  logic guard_start;
  // Field switch-on starts the counter too
  assign field_rise = field_on_in && !state.field_prev;
  // Plain receive command does not arm the guard
  assign guard_start = (tx_done_in && !cmd_is_receive_in) || field_rise;

  rfps_bit_clock #(
    .DIVIDE(BIT_DIVIDE)
  ) u_bit_clock (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .restart_in(guard_start),
    .tick_out(bit_tick)
  );

  rfps_guard_timer #(
    .WIDTH(GUARD_W)
  ) u_guard (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(guard_start),
    .count_in(receive_guard_count),
    .tick_in(bit_tick),
    .busy_out(guard_busy)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // One combinational pass over registers, drivers and muxes
  always_comb begin
    logic mod_src;
    logic a_lvl;
    logic b_lvl;
    mod_src = 1'b0;
    a_lvl = 1'b0;
    b_lvl = 1'b0;
    next_state = state;
    next_state.field_prev = field_on_in;
    // Register writes; reserved bits masked off, so they read zero
    if (reg_write_in) begin
      case (reg_addr_in)
        ADDR_DRV_CTRL: next_state.antenna_driver_control = reg_wdata_in & MASK_DRV_CTRL;
        ADDR_TX_MOD: next_state.tx_modulation_control = reg_wdata_in & MASK_TX_MOD;
        ADDR_TX_SEL: next_state.tx_source_select = reg_wdata_in & MASK_TX_SEL;
        ADDR_RX_SEL: next_state.rx_source_and_guard = reg_wdata_in & MASK_RX_SEL;
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
    // Read data, zero for unmapped addresses
    next_state.rdata = 8'h00;
    if (reg_read_in) begin
      case (reg_addr_in)
        ADDR_DRV_CTRL: next_state.rdata = state.antenna_driver_control;
        ADDR_TX_MOD: next_state.rdata = state.tx_modulation_control;
        ADDR_TX_SEL: next_state.rdata = state.tx_source_select;
        ADDR_RX_SEL: next_state.rdata = state.rx_source_and_guard;
        default: next_state.rdata = 8'h00;
      endcase
    end
    // Modulation source; high envelope means carrier passes
    case (driver_source_select)
      DRV_ENCODER: mod_src = envelope_in;
      DRV_AUX_IN: mod_src = aux_mod_in_pin_in;
      DRV_HIGH: mod_src = 1'b1;
      default: mod_src = 1'b0;
    endcase
    // Driver A: carrier gated by source when enabled, steady at the inv_a_off level when off
    if (a_en) begin
      a_lvl = (carrier_in & mod_src) ^ inv_a_on;
    end else begin
      a_lvl = inv_a_off;
    end
    // Driver B: continuous wave bypasses modulation
    if (b_en) begin
      if (b_cw) begin
        b_lvl = carrier_in ^ inv_b_on;
      end else begin
        b_lvl = (carrier_in & mod_src) ^ inv_b_on;
      end
    end else begin
      b_lvl = inv_b_off;
    end
    next_state.drv_a = a_lvl;
    next_state.drv_b = b_lvl;
    // Code 00 tri-states; in power-down only code 00 does, else drivers hold
    next_state.drv_a_oe = (driver_source_select != DRV_TRISTATE);
    next_state.drv_b_oe = (driver_source_select != DRV_TRISTATE);
    // Aux output select; reserved codes tri-state the pin
    next_state.aux_oe = 1'b1;
    next_state.aux_out = 1'b0;
    case (aux_out_select)
      AUX_TRISTATE: next_state.aux_oe = 1'b0;
      AUX_LOW: next_state.aux_out = 1'b0;
      AUX_HIGH: next_state.aux_out = 1'b1;
      AUX_TEST_BUS: next_state.aux_out = test_bus_in[test_bus_bit_pick_in];
      AUX_ENVELOPE: next_state.aux_out = envelope_in;
      AUX_TX_SERIAL: next_state.aux_out = tx_serial_in;
      AUX_RX_SERIAL: next_state.aux_out = rx_serial_in;
      default: next_state.aux_oe = 1'b0;
    endcase
    // UART input; speed check on NRZ is left to software
    case (cl_uart_input_select)
      UART_LOW: next_state.uart_data = 1'b0;
      UART_AUX_MANCH: next_state.uart_data = aux_mod_in_pin_in;
      UART_ANALOG: next_state.uart_data = analog_rx_in;
      UART_AUX_NRZ: next_state.uart_data = aux_mod_in_pin_in;
      default: next_state.uart_data = 1'b0;
    endcase
    // Receiver input is blanked while the guard runs
    if (guard_busy || guard_start) begin
      next_state.uart_data = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= '0;
      state.antenna_driver_control <= RST_DRV_CTRL;
      state.tx_modulation_control <= RST_TX_MOD;
      state.tx_source_select <= RST_TX_SEL;
      state.rx_source_and_guard <= RST_RX_SEL;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_out = state.rdata;
  assign antenna_driver_a_pin_out = state.drv_a;
  assign antenna_driver_a_pin_oe_out = state.drv_a_oe;
  assign antenna_driver_b_pin_out = state.drv_b;
  assign antenna_driver_b_pin_oe_out = state.drv_b_oe;
  // Full ASK overrides the conductance setting in the analog stage
  assign force_full_ask_out = state.tx_modulation_control[BIT_FORCE_ASK];
  assign aux_mod_out_pin_out = state.aux_out;
  assign aux_mod_out_pin_oe_out = state.aux_oe;
  assign cl_uart_data_out = state.uart_data;
  // Receiver held off for the guard interval
  assign rx_enable_out = !guard_busy;
  // Power-down input is informative only; tri-state follows the source code
  logic unused_pd;
  assign unused_pd = soft_power_down_in;
endmodule

// ===== rfps_card_model.sv
// Far-side model: card reply and aux modulation peer
module rfps_card_model (
  input wire logic clock_in,
  input wire logic aux_level_in,
  input wire logic reply_in,
  output logic aux_pin_out,
  output logic analog_rx_out
);
  // ----------------------------------------
  // Peer levels
  // ----------------------------------------
  initial begin
    aux_pin_out = 1'b0;
    analog_rx_out = 1'b0;
  end
  // Levels move only after an edge, as a real peer would
  always @(posedge clock_in) begin
    aux_pin_out <= aux_level_in;
    analog_rx_out <= reply_in;
  end
endmodule

// ===== rfps_chk.sv
// Checker: port-level assertions for the path select block
module rfps_chk
  import rfps_pkg::*;
#(
  parameter int BIT_DIVIDE = BIT_CLK_DIV
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic carrier_in,
  input wire logic envelope_in,
  input wire logic tx_serial_in,
  input wire logic rx_serial_in,
  input wire logic [7:0] test_bus_in,
  input wire logic [2:0] test_bus_bit_pick_in,
  input wire logic aux_mod_in_pin_in,
  input wire logic aux_mod_out_pin_out,
  input wire logic aux_mod_out_pin_oe_out,
  input wire logic antenna_driver_a_pin_out,
  input wire logic antenna_driver_a_pin_oe_out,
  input wire logic antenna_driver_b_pin_out,
  input wire logic antenna_driver_b_pin_oe_out,
  input wire logic force_full_ask_out,
  input wire logic analog_rx_in,
  input wire logic tx_done_in,
  input wire logic cmd_is_receive_in,
  input wire logic field_on_in,
  input wire logic cl_uart_data_out,
  input wire logic rx_enable_out
);
  // ----------------------------------------
  // Shadow registers and expected levels
  // ----------------------------------------
  logic [7:0] drv_ctrl, tx_mod, tx_sel, rx_sel; // Mirrors of the four registers
  logic live; // Low in the first cycle after reset, when pins still show reset
  logic src_bit, aux_lvl, aux_oe, uart_lvl, exp_a, exp_b;
  logic fld_q; // Field level at the last edge, low through reset
  logic guard_go; // A guard starts at this edge, so the next sample is blanked
  assign guard_go = (tx_done_in && !cmd_is_receive_in) || (field_on_in && !fld_q);
  int low_cycles; // Length of the current receiver hold-off
  always_ff @(posedge clock_in) begin
    live <= !rst_in;
    fld_q <= !rst_in && field_on_in;
    low_cycles <= (rst_in || rx_enable_out) ? 0 : low_cycles + 1;
    if (rst_in) begin
      drv_ctrl <= RST_DRV_CTRL;
      tx_mod <= RST_TX_MOD;
      tx_sel <= RST_TX_SEL;
      rx_sel <= RST_RX_SEL;
    end else if (reg_write_in) begin
      if (reg_addr_in == ADDR_DRV_CTRL) drv_ctrl <= reg_wdata_in & MASK_DRV_CTRL;
      if (reg_addr_in == ADDR_TX_MOD) tx_mod <= reg_wdata_in & MASK_TX_MOD;
      if (reg_addr_in == ADDR_TX_SEL) tx_sel <= reg_wdata_in & MASK_TX_SEL;
      if (reg_addr_in == ADDR_RX_SEL) rx_sel <= reg_wdata_in;
    end
  end
  // Source, aux and UART selections worked out from the shadows
  always_comb begin
    src_bit = (tx_sel[5:4] == DRV_ENCODER) ? envelope_in : (tx_sel[5:4] == DRV_AUX_IN) ? aux_mod_in_pin_in : 1'b1;
    case (tx_sel[3:0])
      AUX_LOW: aux_lvl = 1'b0;
      AUX_HIGH: aux_lvl = 1'b1;
      AUX_TEST_BUS: aux_lvl = test_bus_in[test_bus_bit_pick_in];
      AUX_ENVELOPE: aux_lvl = envelope_in;
      AUX_TX_SERIAL: aux_lvl = tx_serial_in;
      default: aux_lvl = rx_serial_in;
    endcase
    aux_oe = (tx_sel[3:0] != AUX_TRISTATE) && (tx_sel[3:0] != 4'h6) && (tx_sel[3] == 1'b0);
    uart_lvl = (rx_sel[7:6] == UART_LOW) ? 1'b0 : (rx_sel[7:6] == UART_ANALOG) ? analog_rx_in : aux_mod_in_pin_in;
    exp_a = drv_ctrl[0] ? ((carrier_in & src_bit) ^ drv_ctrl[6]) : drv_ctrl[4];
    exp_b = drv_ctrl[1] ? ((drv_ctrl[3] ? carrier_in : carrier_in & src_bit) ^ drv_ctrl[7]) : drv_ctrl[5];
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_guard_start;
    tx_done_in && !cmd_is_receive_in && rx_sel[5:0] != 6'h00;
  endsequence
  sequence s_field_start;
    $rose(field_on_in) && rx_sel[5:0] != 6'h00;
  endsequence
  a_drv_tri_state: assert property (live && $past(tx_sel[5:4]) == DRV_TRISTATE |->
    !antenna_driver_a_pin_oe_out && !antenna_driver_b_pin_oe_out) else $error("drivers not tri-stated");
  a_drv_a_level: assert property (live && $past(tx_sel[5:4]) != DRV_TRISTATE |->
    antenna_driver_a_pin_oe_out && antenna_driver_a_pin_out == $past(exp_a)) else $error("driver a level wrong");
  a_drv_b_level: assert property (live && $past(tx_sel[5:4]) != DRV_TRISTATE |->
    antenna_driver_b_pin_oe_out && antenna_driver_b_pin_out == $past(exp_b)) else $error("driver b level wrong");
  a_aux_pin_out: assert property (live |-> aux_mod_out_pin_oe_out == $past(aux_oe) &&
    (!aux_mod_out_pin_oe_out || aux_mod_out_pin_out == $past(aux_lvl))) else $error("aux pin wrong");
  a_force_full_ask: assert property (live |-> force_full_ask_out == tx_mod[BIT_FORCE_ASK])
    else $error("force ask wrong");
  a_uart_path: assert property (live && $past(rx_enable_out && !guard_go) |->
    cl_uart_data_out == $past(uart_lvl)) else $error("uart input wrong");
  a_guard_blank: assert property (live && $past(!rx_enable_out || guard_go) |-> !cl_uart_data_out)
    else $error("receiver not blanked");
  a_guard_start: assert property (s_guard_start |=> !rx_enable_out) else $error("guard not started");
  a_guard_skip: assert property (tx_done_in && cmd_is_receive_in && rx_enable_out && !field_on_in |=>
    rx_enable_out) else $error("guard applied to receive");
  a_field_start: assert property (s_field_start |=> !rx_enable_out) else $error("field guard missing");
  a_guard_length: assert property ($rose(rx_enable_out) |-> low_cycles >= int'(rx_sel[5:0]) * BIT_DIVIDE &&
    low_cycles <= int'(rx_sel[5:0]) * BIT_DIVIDE + 1) else $error("guard length wrong");
endmodule
bind rfps_path_select rfps_chk #(.BIT_DIVIDE(BIT_DIVIDE)) i_chk (.clock_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_write_in, .carrier_in, .envelope_in, .tx_serial_in, .rx_serial_in, .test_bus_in, .test_bus_bit_pick_in,
  .aux_mod_in_pin_in, .aux_mod_out_pin_out, .aux_mod_out_pin_oe_out, .antenna_driver_a_pin_out,
  .antenna_driver_a_pin_oe_out, .antenna_driver_b_pin_out, .antenna_driver_b_pin_oe_out, .force_full_ask_out,
  .analog_rx_in, .tx_done_in, .cmd_is_receive_in, .field_on_in, .cl_uart_data_out, .rx_enable_out);

// ===== rfps_path_select_tb.sv
// Testbench: registers, drivers, aux pin, uart input and receive guard
module rfps_path_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rfps_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int DIV = 4; // Short bit-clock keeps the guard test brief
  logic clock_in = 0, rst_in = 1, reg_write_in = 0, reg_read_in = 0, carrier_in = 1, envelope_in = 0;
  logic tx_serial_in = 0, rx_serial_in = 0, soft_power_down_in = 0, tx_done_in = 0, cmd_is_receive_in = 0;
  logic field_on_in = 0, aux_lvl = 0, reply = 0;
  logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, test_bus_in = 0, reg_rdata_out;
  logic [2:0] test_bus_bit_pick_in = 0;
  logic aux_mod_in_pin_in, analog_rx_in, aux_mod_out_pin_out, aux_mod_out_pin_oe_out, force_full_ask_out;
  logic antenna_driver_a_pin_out, antenna_driver_a_pin_oe_out, antenna_driver_b_pin_out;
  logic antenna_driver_b_pin_oe_out, cl_uart_data_out, rx_enable_out;
  int n_fail = 0, total_checks = 0;
  rfps_card_model i_card (.clock_in, .aux_level_in(aux_lvl), .reply_in(reply), .aux_pin_out(aux_mod_in_pin_in),
    .analog_rx_out(analog_rx_in));
  rfps_path_select #(.BIT_DIVIDE(DIV)) i_dut (.clock_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .carrier_in, .envelope_in, .tx_serial_in, .rx_serial_in, .test_bus_in,
    .test_bus_bit_pick_in, .soft_power_down_in, .aux_mod_in_pin_in, .aux_mod_out_pin_out, .aux_mod_out_pin_oe_out,
    .antenna_driver_a_pin_out, .antenna_driver_a_pin_oe_out, .antenna_driver_b_pin_out,
    .antenna_driver_b_pin_oe_out, .force_full_ask_out, .analog_rx_in, .tx_done_in, .cmd_is_receive_in,
    .field_on_in, .cl_uart_data_out, .rx_enable_out);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata_out);
  endtask
  // Three edges: peer delay plus the registered pins
  task automatic settle;
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd8(ADDR_DRV_CTRL, 8'h80);
    rd8(ADDR_TX_MOD, 8'h00);
    rd8(ADDR_TX_SEL, 8'h10);
    rd8(ADDR_RX_SEL, 8'h84);
    wr8(8'h18, 8'hff);
    rd8(8'h18, 8'h00);
    wr8(ADDR_DRV_CTRL, 8'hff);
    rd8(ADDR_DRV_CTRL, 8'hfb);
    wr8(ADDR_TX_MOD, 8'hff);
    rd8(ADDR_TX_MOD, 8'h40);
    settle;
    chk("force ask", 8'h01, {7'h0, force_full_ask_out});
    wr8(ADDR_TX_MOD, 8'h00);
    settle;
    chk("force ask", 8'h00, {7'h0, force_full_ask_out});
    $display("test registers done");
  endtask
  // Every source code against inversion, enable and continuous-wave settings
  task automatic t_drivers;
    logic [7:0] ctl [5] = '{8'h03, 8'hc3, 8'h30, 8'h00, 8'h0a};
    logic s, ea, eb, oe;
    for (int e = 0; e < 4; e++) begin
      envelope_in <= e[0];
      aux_lvl <= !e[0];
      carrier_in <= e[1];
      soft_power_down_in <= e[1];
      for (int i = 0; i < 5; i++) begin
        for (int k = 0; k < 4; k++) begin
          wr8(ADDR_DRV_CTRL, ctl[i]);
          wr8(ADDR_TX_SEL, 8'(k << 4));
          settle;
          s = (k == 1) ? e[0] : (k == 2) ? !e[0] : (k == 3);
          ea = ctl[i][0] ? ((e[1] & s) ^ ctl[i][6]) : ctl[i][4];
          eb = ctl[i][1] ? (((ctl[i][3] | s) & e[1]) ^ ctl[i][7]) : ctl[i][5];
          oe = (k != 0);
          chk("driver oe", {6'h0, oe, oe}, {6'h0, antenna_driver_a_pin_oe_out, antenna_driver_b_pin_oe_out});
          if (oe) chk("driver level", {6'h0, ea, eb}, {6'h0, antenna_driver_a_pin_out, antenna_driver_b_pin_out});
        end
      end
    end
    $display("test drivers done");
  endtask
  task automatic t_aux;
    logic v, oe;
    for (int p = 0; p < 4; p++) begin
      test_bus_in <= (8'h01 << (p + 1)) ^ (p[0] ? 8'hff : 8'h00);
      test_bus_bit_pick_in <= 3'(p + 1);
      envelope_in <= p[0];
      tx_serial_in <= p[1];
      rx_serial_in <= p[0] ^ p[1];
      for (int k = 0; k < 9; k++) begin
        wr8(ADDR_TX_SEL, 8'(k));
        settle;
        v = (k == 2) || (k == 3 && !p[0]) || (k == 4 && p[0]) || (k == 5 && p[1]) || (k == 7 && (p[0] ^ p[1]));
        oe = (k != 0) && (k != 6) && (k != 8);
        chk("aux oe", {7'h0, oe}, {7'h0, aux_mod_out_pin_oe_out});
        if (oe) chk("aux level", {7'h0, v}, {7'h0, aux_mod_out_pin_out});
      end
    end
    $display("test aux pin done");
  endtask
  task automatic t_uart;
    logic v;
    for (int p = 0; p < 2; p++) begin
      aux_lvl <= p[0];
      reply <= !p[0];
      for (int k = 0; k < 4; k++) begin
        wr8(ADDR_RX_SEL, 8'(k << 6));
        settle;
        v = (k == 0) ? 1'b0 : (k == 2) ? !p[0] : p[0];
        chk("uart input", {7'h0, v}, {7'h0, cl_uart_data_out});
      end
    end
    $display("test uart input done");
  endtask
  task automatic t_guard;
    int n;
    wr8(ADDR_RX_SEL, 8'h83);
    reply <= 1'b1;
    settle;
    tx_done_in <= 1'b1;
    @(posedge clock_in);
    tx_done_in <= 1'b0;
    n = 0;
    #1;
    while (rx_enable_out !== 1'b1 && n < 500) begin
      n++;
      if (n == 4) chk("uart blank", 8'h00, {7'h0, cl_uart_data_out});
      @(posedge clock_in);
      #1;
    end
    chk("guard length", 8'(3 * DIV), (n == 3 * DIV + 1) ? 8'(3 * DIV) : 8'(n));
    cmd_is_receive_in <= 1'b1;
    tx_done_in <= 1'b1;
    @(posedge clock_in);
    tx_done_in <= 1'b0;
    settle;
    chk("rx enable", 8'h01, {7'h0, rx_enable_out});
    field_on_in <= 1'b1;
    @(posedge clock_in);
    #1;
    chk("rx enable", 8'h00, {7'h0, rx_enable_out});
    repeat (30) @(posedge clock_in);
    $display("test receive guard done");
  endtask
  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    t_regs;
    t_drivers;
    t_aux;
    t_uart;
    t_guard;
    results;
  end
  // About nine hundred cycles are expected; fifty-five times that means a hang
  initial begin
    #1000000;
    n_fail++;
    results;
  end
endmodule
